// ### fsr_fault_status.sv
/*
 * fault and status word logic of a power supply management interface:
 * a vendor fault status word, a thermal fault status word, and an
 * interrupt status and mask pair, all read by command code.
 * assumes all condition inputs are synchronous to clk_i, already
 * debounced and compared against their thresholds elsewhere; the
 * power-on reset stands for an input power cycle.
 */
// Summary of operation
// - bulk short on either rail latches b14
// - bulk 2 overvoltage latches b13
// - bulk 1 overvoltage latches b12
// - bulk rail regulation mismatch latches b11
// - bulk 2 undervoltage latches b10
// - bulk 1 undervoltage latches b9
// - b8 follows bulk at nominal level
// - isolated supply monitor input sets sticky b7
// - converter supply monitor input sets sticky b6
// - preregulator supply monitor input sets sticky b5
// - b1 reads one parallel, zero series
// - thermal b15 tracks preregulator switch overheat
// - thermal b14 tracks freewheel 2 overheat
// - thermal b13 tracks freewheel 1 overheat
// - thermal b10 tracks auxiliary sensor overheat
// - thermal b9 tracks ambient sensor overheat
// - thermal b7 is OR of bits 15..9
`timescale 1ns/1ps
module fsr_fault_status (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,

    // register port
    input wire logic [fsr_pkg::ADDR_W-1:0] addr_i,
    input wire logic [fsr_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [fsr_pkg::DATA_W-1:0] rdata_o,

    // bulk rail conditions
    input wire logic bulk1_short_i,
    input wire logic bulk2_short_i,
    input wire logic bulk1_over_volt_i,
    input wire logic bulk2_over_volt_i,
    input wire logic bulk_mismatch_i,
    input wire logic bulk1_under_volt_i,
    input wire logic bulk2_under_volt_i,
    input wire logic bulk_good_i,

    // external supply monitors
    input wire logic isolated_supply_monitor_i,
    input wire logic converter_supply_monitor_i,
    input wire logic preregulator_supply_monitor_i,

    // other primary conditions
    input wire logic rail_imbalance_i,
    input wire logic primary_overcurrent_i,
    input wire logic input_parallel_i,

    // temperature sensor comparisons
    input wire logic preregulator_switch_hot_i,
    input wire logic freewheel2_hot_i,
    input wire logic freewheel1_hot_i,
    input wire logic transformer2_hot_i,
    input wire logic transformer1_hot_i,
    input wire logic aux_sensor_hot_i,
    input wire logic ambient_sensor_hot_i,

    // interrupt
    output logic irq_o
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed
    {
        logic [fsr_pkg::DATA_W-1:0] rdata;
        logic irq;
        logic thermal_prev;
    } fsr_top_state_t;

    fsr_top_state_t st;
    fsr_top_state_t next_st;

    logic [fsr_pkg::LAT_W-1:0] lat_set;
    logic [fsr_pkg::LAT_W-1:0] lat_flags;
    logic [fsr_pkg::LAT_W-1:0] lat_rose;
    logic [fsr_pkg::STK_W-1:0] stk_set;
    logic [fsr_pkg::STK_W-1:0] stk_flags;
    logic [fsr_pkg::STK_W-1:0] stk_rose;
    logic [fsr_pkg::DATA_W-1:0] vendor_fault_status;
    logic [fsr_pkg::DATA_W-1:0] thermal_fault_status;
    logic any_thermal_fault;
    logic [fsr_pkg::INT_W-1:0] int_event;
    logic [fsr_pkg::INT_W-1:0] int_status;
    logic [fsr_pkg::INT_W-1:0] int_mask;
    logic int_irq;
    logic int_status_wr;
    logic int_mask_wr;

    // ************************************************************
    // power-cycle latched faults
    // ************************************************************
    always_comb
    begin
        lat_set = '0;
        lat_set[fsr_pkg::LAT_BULK_SHORT] =
            bulk1_short_i | bulk2_short_i;
        lat_set[fsr_pkg::LAT_BULK2_OVER_VOLT] = bulk2_over_volt_i;
        lat_set[fsr_pkg::LAT_BULK1_OVER_VOLT] = bulk1_over_volt_i;
        lat_set[fsr_pkg::LAT_BULK_MISMATCH] = bulk_mismatch_i;
        lat_set[fsr_pkg::LAT_BULK2_UNDER_VOLT] = bulk2_under_volt_i;
        lat_set[fsr_pkg::LAT_BULK1_UNDER_VOLT] = bulk1_under_volt_i;
        lat_set[fsr_pkg::LAT_RAIL_IMBALANCE] = rail_imbalance_i;
    end

    // no software clear exists: only the power-on reset drops these
    fsr_flag_latch #(
        .W(fsr_pkg::LAT_W)
    )
    u_latched (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .set_i(lat_set),
        .flags_o(lat_flags),
        .rose_o(lat_rose)
    );

    // ************************************************************
    // sticky supply monitor flags
    // ************************************************************
    always_comb
    begin
        stk_set = '0;
        stk_set[fsr_pkg::STK_ISO] = isolated_supply_monitor_i;
        stk_set[fsr_pkg::STK_CONV] = converter_supply_monitor_i;
        stk_set[fsr_pkg::STK_PREREG] =
            preregulator_supply_monitor_i;
    end

    fsr_flag_latch #(
        .W(fsr_pkg::STK_W)
    )
    u_sticky (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .set_i(stk_set),
        .flags_o(stk_flags),
        .rose_o(stk_rose)
    );

    // ************************************************************
    // vendor fault status word
    // ************************************************************
    always_comb
    begin
        // unassigned positions stay zero
        vendor_fault_status = fsr_pkg::WORD_RESET;
        vendor_fault_status[fsr_pkg::VF_BULK_SHORT] =
            lat_flags[fsr_pkg::LAT_BULK_SHORT];
        vendor_fault_status[fsr_pkg::VF_BULK2_OVER_VOLT] =
            lat_flags[fsr_pkg::LAT_BULK2_OVER_VOLT];
        vendor_fault_status[fsr_pkg::VF_BULK1_OVER_VOLT] =
            lat_flags[fsr_pkg::LAT_BULK1_OVER_VOLT];
        vendor_fault_status[fsr_pkg::VF_BULK_MISMATCH] =
            lat_flags[fsr_pkg::LAT_BULK_MISMATCH];
        vendor_fault_status[fsr_pkg::VF_BULK2_UNDER_VOLT] =
            lat_flags[fsr_pkg::LAT_BULK2_UNDER_VOLT];
        vendor_fault_status[fsr_pkg::VF_BULK1_UNDER_VOLT] =
            lat_flags[fsr_pkg::LAT_BULK1_UNDER_VOLT];
        vendor_fault_status[fsr_pkg::VF_BULK_GOOD] = bulk_good_i;
        vendor_fault_status[fsr_pkg::VF_ISO_MON] =
            stk_flags[fsr_pkg::STK_ISO];
        vendor_fault_status[fsr_pkg::VF_CONV_SUPPLY_MON] =
            stk_flags[fsr_pkg::STK_CONV];
        vendor_fault_status[fsr_pkg::VF_PREREG_SUPPLY_MON] =
            stk_flags[fsr_pkg::STK_PREREG];
        vendor_fault_status[fsr_pkg::VF_RAIL_IMBALANCE] =
            lat_flags[fsr_pkg::LAT_RAIL_IMBALANCE];
        // primary overcurrent recovers by itself
        vendor_fault_status[fsr_pkg::VF_PRIMARY_OC] = primary_overcurrent_i;
        vendor_fault_status[fsr_pkg::VF_INPUT_PARALLEL] =
            input_parallel_i;
    end

    // ************************************************************
    // thermal fault status word
    // ************************************************************
    always_comb
    begin
        thermal_fault_status = fsr_pkg::WORD_RESET;
        // every sensor bit follows its live comparison, no latching
        thermal_fault_status[fsr_pkg::TF_PREREG_SWITCH_HOT] =
            preregulator_switch_hot_i;
        thermal_fault_status[fsr_pkg::TF_FREEWHEEL2_HOT] =
            freewheel2_hot_i;
        thermal_fault_status[fsr_pkg::TF_FREEWHEEL1_HOT] =
            freewheel1_hot_i;
        thermal_fault_status[fsr_pkg::TF_TRANSFORMER2_HOT] =
            transformer2_hot_i;
        thermal_fault_status[fsr_pkg::TF_TRANSFORMER1_HOT] =
            transformer1_hot_i;
        thermal_fault_status[fsr_pkg::TF_AUX_SENSOR_HOT] =
            aux_sensor_hot_i;
        thermal_fault_status[fsr_pkg::TF_AMBIENT_SENSOR_HOT] =
            ambient_sensor_hot_i;
        any_thermal_fault = |thermal_fault_status[
            fsr_pkg::TF_SUMMARY_HI:fsr_pkg::TF_SUMMARY_LO];
        thermal_fault_status[fsr_pkg::TF_ANY_THERMAL] =
            any_thermal_fault;
    end

    // ************************************************************
    // interrupt events and register decode
    // ************************************************************
    always_comb
    begin
        int_event = '0;
        int_event[fsr_pkg::INT_LATCHED_FAULT] = |lat_rose;
        int_event[fsr_pkg::INT_SUPPLY_MONITOR] = |stk_rose;
        // thermal bits are live, so only the onset is an event
        int_event[fsr_pkg::INT_THERMAL_ONSET] =
            ce_i & any_thermal_fault & ~st.thermal_prev;
    end

    assign int_status_wr = wr_i && (addr_i == fsr_pkg::INT_STATUS_ADDR);
    assign int_mask_wr = wr_i && (addr_i == fsr_pkg::INT_MASK_ADDR);

    fsr_irq_ctrl u_irq (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .event_i(int_event),
        .status_wr_i(int_status_wr),
        .mask_wr_i(int_mask_wr),
        .wdata_i(wdata_i[fsr_pkg::INT_W-1:0]),
        .status_o(int_status),
        .mask_o(int_mask),
        .irq_o(int_irq)
    );

    // ************************************************************
    // read path and output flops
    // ************************************************************
    always_comb
    begin
        next_st = st;
        if (ce_i)
        begin
            next_st.thermal_prev = any_thermal_fault;
            // irq in the controller is a flop; this copy keeps the
            // top output on a flop at the cost of one cycle of delay
            next_st.irq = int_irq;
            // read data stand until the next enabled cycle, then fall back to zero
            next_st.rdata = fsr_pkg::WORD_RESET;
            if (rd_i)
            begin
                unique case (addr_i)
                    fsr_pkg::VENDOR_FAULT_STATUS_ADDR:
                    begin
                        next_st.rdata = vendor_fault_status;
                    end
                    fsr_pkg::THERMAL_FAULT_STATUS_ADDR:
                    begin
                        next_st.rdata = thermal_fault_status;
                    end
                    fsr_pkg::INT_STATUS_ADDR:
                    begin
                        next_st.rdata[fsr_pkg::INT_W-1:0] = int_status;
                    end
                    fsr_pkg::INT_MASK_ADDR:
                    begin
                        next_st.rdata[fsr_pkg::INT_W-1:0] = int_mask;
                    end
                    default:
                    begin
                        // unmapped codes answer zero
                        next_st.rdata = fsr_pkg::WORD_RESET;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st.rdata <= fsr_pkg::WORD_RESET;
            st.irq <= 1'b0;
            st.thermal_prev <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign irq_o = st.irq;

endmodule

// ### fsr_fault_status_props.sv
/*
 * checker of the fault and status word logic at its top ports.
 * assumes a single clock domain and the port read timing of one cycle.
 */
`timescale 1ns/1ps
module fsr_fault_status_props (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // register port
    input wire logic [fsr_pkg::ADDR_W-1:0] addr_i,
    input wire logic rd_i,
    input wire logic [fsr_pkg::DATA_W-1:0] rdata_o,
    // watched conditions
    input wire logic bulk1_short_i,
    input wire logic bulk2_short_i,
    input wire logic bulk2_over_volt_i,
    input wire logic bulk_good_i,
    input wire logic input_parallel_i,
    input wire logic isolated_supply_monitor_i,
    input wire logic preregulator_switch_hot_i,
    input wire logic ambient_sensor_hot_i
);
    // ****************************************
    // read sequences
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_rd74;
        ce_i && rd_i && addr_i == fsr_pkg::VENDOR_FAULT_STATUS_ADDR;
    endsequence
    sequence s_rd76;
        ce_i && rd_i && addr_i == fsr_pkg::THERMAL_FAULT_STATUS_ADDR;
    endsequence

    // ****************************************
    // properties
    // ****************************************
    property p_unmapped;
        ce_i && rd_i && addr_i == 8'h75 |=> rdata_o == 16'h0000;
    endproperty
    property p_undef;
        s_rd74 |=> !rdata_o[15] && !rdata_o[4] && !rdata_o[0];
    endproperty
    property p_good;
        s_rd74 |=> rdata_o[8] == $past(bulk_good_i);
    endproperty
    property p_parallel;
        s_rd74 |=> rdata_o[1] == $past(input_parallel_i);
    endproperty
    // a flag registered at the edge before the read must already show
    property p_short;
        ce_i && (bulk1_short_i || bulk2_short_i) ##1 s_rd74 |=> rdata_o[14];
    endproperty
    property p_ov2;
        ce_i && bulk2_over_volt_i ##1 s_rd74 |=> rdata_o[13];
    endproperty
    property p_iso;
        ce_i && isolated_supply_monitor_i ##1 s_rd74 |=> rdata_o[7];
    endproperty
    property p_sum;
        s_rd76 |=> rdata_o[7] == |rdata_o[15:9];
    endproperty
    property p_switch_hot;
        s_rd76 |=> rdata_o[15] == $past(preregulator_switch_hot_i);
    endproperty
    property p_ambient;
        s_rd76 |=> rdata_o[9] == $past(ambient_sensor_hot_i);
    endproperty

    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_undef: assert property (p_undef)
        else $error("undefined vendor bit set");
    a_good: assert property (p_good)
        else $error("bulk good bit wrong");
    a_parallel: assert property (p_parallel)
        else $error("input config bit wrong");
    a_short: assert property (p_short)
        else $error("bulk short flag missing");
    a_ov2: assert property (p_ov2)
        else $error("bulk2 overvoltage flag missing");
    a_iso: assert property (p_iso)
        else $error("isolated monitor flag missing");
    a_sum: assert property (p_sum)
        else $error("thermal summary wrong");
    a_switch_hot: assert property (p_switch_hot)
        else $error("switch hot bit wrong");
    a_ambient: assert property (p_ambient)
        else $error("ambient hot bit wrong");
endmodule

bind fsr_fault_status fsr_fault_status_props u_props (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .bulk1_short_i(bulk1_short_i), .bulk2_short_i(bulk2_short_i),
    .bulk2_over_volt_i(bulk2_over_volt_i), .bulk_good_i(bulk_good_i),
    .input_parallel_i(input_parallel_i),
    .isolated_supply_monitor_i(isolated_supply_monitor_i),
    .preregulator_switch_hot_i(preregulator_switch_hot_i),
    .ambient_sensor_hot_i(ambient_sensor_hot_i)
);

// ### fsr_flag_latch.sv
/*
 * bank of set-only flags: a flag rises with its set input and holds
 * until reset; also reports which flags rose in the current cycle.
 * assumes set inputs synchronous to clk_i.
 */
`timescale 1ns/1ps
module fsr_flag_latch #(
    parameter int W = 1
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // flags
    input wire logic [W-1:0] set_i,
    output logic [W-1:0] flags_o,
    output logic [W-1:0] rose_o
);

    typedef struct packed
    {
        logic [W-1:0] flags;
    } fsr_latch_state_t;

    fsr_latch_state_t st;
    fsr_latch_state_t next_st;

    always_comb
    begin
        next_st = st;
        if (ce_i)
        begin
            next_st.flags = st.flags | set_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign flags_o = st.flags;
    // only a first rise counts, a flag already held raises no event
    assign rose_o = ce_i ? (set_i & ~st.flags) : '0;

endmodule

// ### fsr_host.sv
/*
 * host model on the register port: single accesses and random traffic.
 * assumes the slave never stalls; signals change after a rising edge.
 */
`timescale 1ns/1ps
module fsr_host (
    // clock
    input wire logic clk_i,
    // register port
    output logic [7:0] addr_o,
    output logic [15:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // released lines show the inverse so stale values are never reused
    task automatic access(input logic [7:0] a, input logic [15:0] d,
                          input logic w);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= w;
        rd_o <= ~w;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask

    // back-to-back strobes of random kind and command code
    task automatic rnd(input int n);
        logic [1:0] k;
        repeat (n)
        begin
            @(posedge clk_i);
            k = 2'($urandom);
            rd_o <= k[0];
            wr_o <= k[1] & ~k[0];
            addr_o <= 8'h70 + 8'($urandom % 16);
            wdata_o <= 16'($urandom);
        end
        @(posedge clk_i);
        rd_o <= 1'b0;
        wr_o <= 1'b0;
    endtask
endmodule

// ### fsr_irq_ctrl.sv
/*
 * interrupt status (write one to clear), mask and level interrupt.
 * assumes one-cycle event pulses and one-cycle write strobes.
 */
`timescale 1ns/1ps
module fsr_irq_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // events and software access
    input wire logic [fsr_pkg::INT_W-1:0] event_i,
    input wire logic status_wr_i,
    input wire logic mask_wr_i,
    input wire logic [fsr_pkg::INT_W-1:0] wdata_i,
    // state
    output logic [fsr_pkg::INT_W-1:0] status_o,
    output logic [fsr_pkg::INT_W-1:0] mask_o,
    output logic irq_o
);

    typedef struct packed
    {
        logic [fsr_pkg::INT_W-1:0] status;
        logic [fsr_pkg::INT_W-1:0] mask;
        logic irq;
    } fsr_irq_state_t;

    fsr_irq_state_t st;
    fsr_irq_state_t next_st;

    always_comb
    begin
        next_st = st;
        if (ce_i)
        begin
            // set beats clear so an event in the clearing cycle survives
            if (status_wr_i)
            begin
                next_st.status = (st.status & ~wdata_i) | event_i;
            end
            else
            begin
                next_st.status = st.status | event_i;
            end
            if (mask_wr_i)
            begin
                next_st.mask = wdata_i;
            end
            next_st.irq = |(next_st.status & next_st.mask);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st.status <= '0;
            st.mask <= fsr_pkg::INT_MASK_RESET;
            st.irq <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign status_o = st.status;
    assign mask_o = st.mask;
    assign irq_o = st.irq;

endmodule

// ### fsr_pkg.sv
/*
 * constants for the power supply fault and status word logic:
 * command codes, bit positions of both status words, interrupt layout.
 * assumes a management bus front end that hands over command codes as
 * a plain 8-bit address.
 */
package fsr_pkg;

    // ************************************************************
    // bus shape
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // ************************************************************
    // command codes
    // ************************************************************
    localparam logic [7:0] VENDOR_FAULT_STATUS_ADDR = 8'h74;
    localparam logic [7:0] THERMAL_FAULT_STATUS_ADDR = 8'h76;
    localparam logic [7:0] INT_STATUS_ADDR = 8'h78;
    localparam logic [7:0] INT_MASK_ADDR = 8'h7a;

    localparam logic [15:0] WORD_RESET = 16'h0000;

    // ************************************************************
    // vendor fault status word bit positions
    // ************************************************************
    localparam int VF_BULK_SHORT = 14;
    localparam int VF_BULK2_OVER_VOLT = 13;
    localparam int VF_BULK1_OVER_VOLT = 12;
    localparam int VF_BULK_MISMATCH = 11;
    localparam int VF_BULK2_UNDER_VOLT = 10;
    localparam int VF_BULK1_UNDER_VOLT = 9;
    localparam int VF_BULK_GOOD = 8;
    localparam int VF_ISO_MON = 7;
    localparam int VF_CONV_SUPPLY_MON = 6;
    localparam int VF_PREREG_SUPPLY_MON = 5;
    localparam int VF_RAIL_IMBALANCE = 3;
    localparam int VF_PRIMARY_OC = 2;
    localparam int VF_INPUT_PARALLEL = 1;

    // ************************************************************
    // thermal fault status word bit positions
    // ************************************************************
    localparam int TF_PREREG_SWITCH_HOT = 15;
    localparam int TF_FREEWHEEL2_HOT = 14;
    localparam int TF_FREEWHEEL1_HOT = 13;
    localparam int TF_TRANSFORMER2_HOT = 12;
    localparam int TF_TRANSFORMER1_HOT = 11;
    localparam int TF_AUX_SENSOR_HOT = 10;
    localparam int TF_AMBIENT_SENSOR_HOT = 9;
    localparam int TF_ANY_THERMAL = 7;
    localparam int TF_SUMMARY_HI = 15;
    localparam int TF_SUMMARY_LO = 9;

    // ************************************************************
    // power-cycle latched group: index inside the latch vector
    // ************************************************************
    localparam int LAT_W = 7;
    localparam int LAT_BULK_SHORT = 0;
    localparam int LAT_BULK2_OVER_VOLT = 1;
    localparam int LAT_BULK1_OVER_VOLT = 2;
    localparam int LAT_BULK_MISMATCH = 3;
    localparam int LAT_BULK2_UNDER_VOLT = 4;
    localparam int LAT_BULK1_UNDER_VOLT = 5;
    localparam int LAT_RAIL_IMBALANCE = 6;

    // ************************************************************
    // sticky supply monitor group
    // ************************************************************
    localparam int STK_W = 3;
    localparam int STK_ISO = 0;
    localparam int STK_CONV = 1;
    localparam int STK_PREREG = 2;

    // ************************************************************
    // interrupt status and mask layout
    // ************************************************************
    localparam int INT_W = 3;
    localparam int INT_LATCHED_FAULT = 0;
    localparam int INT_SUPPLY_MONITOR = 1;
    localparam int INT_THERMAL_ONSET = 2;
    localparam logic [2:0] INT_MASK_RESET = 3'h0;

endpackage

// ### test_fsr_fault_status.sv
/*
 * self-checking bench of the fault and status word logic with a
 * cycle model compared at every edge.
 * assumes fsr_host drives the register port.
 */
`timescale 1ns/1ps
module test_fsr_fault_status;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic [20:0] c = '0;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata_o;
    logic irq_o;
    logic [15:0] vl, e_rd, set, live, th;
    logic [2:0] st, mk, ev;
    logic psum, e_irq;
    logic [7:0] adr [5] = '{8'h74, 8'h76, 8'h78, 8'h7a, 8'h75};
    int fails = 0;
    int checked = 0;

    always #5 clk_i = ~clk_i;

    fsr_host host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata),
                   .wr_o(wr), .rd_o(rd));

    fsr_fault_status uut (
        .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata_o),
        .bulk1_short_i(c[0]), .bulk2_short_i(c[1]),
        .bulk1_over_volt_i(c[2]), .bulk2_over_volt_i(c[3]),
        .bulk_mismatch_i(c[4]), .bulk1_under_volt_i(c[5]),
        .bulk2_under_volt_i(c[6]), .bulk_good_i(c[7]),
        .isolated_supply_monitor_i(c[8]),
        .converter_supply_monitor_i(c[9]),
        .preregulator_supply_monitor_i(c[10]),
        .rail_imbalance_i(c[11]), .primary_overcurrent_i(c[12]),
        .input_parallel_i(c[13]), .preregulator_switch_hot_i(c[14]),
        .freewheel2_hot_i(c[15]), .freewheel1_hot_i(c[16]),
        .transformer2_hot_i(c[17]), .transformer1_hot_i(c[18]),
        .aux_sensor_hot_i(c[19]), .ambient_sensor_hot_i(c[20]),
        .irq_o(irq_o)
    );

    // ****************************************
    // comparison and verdict
    // ****************************************
    task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
        checked++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic chk(string n, logic [15:0] m);
        cmp(n, e_rd & m, rdata_o & m);
    endtask

    task automatic end_of_test;
        $display("fails=%0d checked=%0d", fails, checked);
        if (fails == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ****************************************
    // cycle model
    // ****************************************
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            vl = '0;
            st = '0;
            mk = '0;
            psum = 1'b0;
            e_rd = '0;
            e_irq = 1'b0;
        end
        else
        begin
            chk("b15:12", 16'hf000);
            chk("b11:8", 16'h0f00);
            chk("b7:4", 16'h00f0);
            chk("b3:0", 16'h000f);
            cmp("irq", {15'h0, e_irq}, {15'h0, irq_o});
            // ce low freezes every output, so the expectations hold
            if (ce_i)
            begin
                set = {1'b0, c[0] | c[1], c[3], c[2], c[4], c[6], c[5],
                       1'b0, c[8], c[9], c[10], 1'b0, c[11], 3'b0};
                live = {7'b0, c[7], 5'b0, c[12], c[13], 1'b0};
                th = {c[14], c[15], c[16], c[17], c[18], c[19], c[20],
                      1'b0, |c[20:14], 7'b0};
                ev = {th[7] & ~psum, |(set & ~vl & 16'h00e0),
                      |(set & ~vl & 16'h7e08)};
                e_irq = |(st & mk);
                e_rd = '0;
                if (rd)
                begin
                    case (addr)
                        8'h74: e_rd = vl | live;
                        8'h76: e_rd = th;
                        8'h78: e_rd = {13'h0, st};
                        8'h7a: e_rd = {13'h0, mk};
                        default: e_rd = '0;
                    endcase
                end
                if (wr && addr == 8'h78)
                    st = st & ~wdata[2:0];
                st = st | ev;
                if (wr && addr == 8'h7a)
                    mk = wdata[2:0];
                vl = vl | set;
                psum = th[7];
            end
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    task automatic rd_all;
        foreach (adr[i])
            host.access(adr[i], 16'h0000, 1'b0);
    endtask

    task automatic pulse_reset;
        @(posedge clk_i);
        resetn_i <= 1'b0;
        @(posedge clk_i);
        resetn_i <= 1'b1;
    endtask

    initial
    begin
        void'($urandom(48));
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        // read-only words ignore writes
        host.access(8'h74, 16'hffff, 1'b1);
        host.access(8'h76, 16'hffff, 1'b1);
        rd_all();
        host.access(8'h7a, 16'h0007, 1'b1);
        // one condition at a time: latched stay, live ones drop
        for (int i = 0; i < 21; i++)
        begin
            @(posedge clk_i);
            c <= 21'h1 << i;
            rd_all();
            @(posedge clk_i);
            c <= '0;
            rd_all();
        end
        host.access(8'h78, 16'h0007, 1'b1);
        rd_all();
        // latched flags survive until the next power-on reset only
        repeat (3)
        begin
            pulse_reset();
            fork
                host.rnd(300);
                repeat (300)
                begin
                    @(posedge clk_i);
                    c <= 21'($urandom) & 21'($urandom) & 21'($urandom);
                    ce_i <= ($urandom % 8) != 0;
                end
            join
            ce_i <= 1'b1;
            rd_all();
        end
        end_of_test();
    end

    initial
    begin
        #100us;
        fails++;
        end_of_test();
    end
endmodule
